// [hdl/mlfm_pkg.sv]
// Package for the lock-current, motor-lock and startup-fault manager.
// Assumes a single 10 MHz clock domain and a classic Wishbone register slave.
package mlfm_pkg;
  // Clock rate
  localparam int unsigned CLK_HZ        = 10_000_000;
  // Register word offsets (byte addresses)
  localparam logic [7:0]  REG_CONFIG    = 8'h00;
  localparam logic [7:0]  REG_THRESH    = 8'h04;
  localparam logic [7:0]  REG_TIMING    = 8'h08;
  localparam logic [7:0]  REG_CONTROL   = 8'h0c;
  localparam logic [7:0]  REG_STATUS    = 8'h10;
  // Reset values
  localparam logic [31:0] CONFIG_RST    = 32'h0000_0000;
  localparam logic [31:0] THRESH_RST    = 32'hffff_ffff;
  localparam logic [31:0] TIMING_RST    = 32'h0010_0010;
  // Config field positions
  localparam int unsigned CF_LC_MODE    = 0;
  localparam int unsigned CF_ML_MODE    = 4;
  localparam int unsigned CF_SPD_EN     = 8;
  localparam int unsigned CF_SYNC_EN    = 9;
  localparam int unsigned CF_ABS_EN     = 10;
  localparam int unsigned CF_MISS_CNT   = 12;
  localparam int unsigned CF_STARTUP    = 16;
  localparam logic [1:0]  STARTUP_IND   = 2'h2;
  // Status bit positions
  localparam int unsigned ST_CTRL       = 0;
  localparam int unsigned ST_LOCKCUR    = 1;
  localparam int unsigned ST_MLOCK      = 2;
  localparam int unsigned ST_OVSPD      = 3;
  localparam int unsigned ST_SYNC       = 4;
  localparam int unsigned ST_ABSENT     = 5;
  localparam int unsigned ST_RAMPUP     = 6;
  localparam int unsigned ST_RAMPDN     = 7;
  localparam int unsigned ST_RATE       = 8;
  // Inductance timer prescale steps: 10 MHz, 1 MHz, 100 kHz, 10 kHz
  localparam int unsigned IND_STEPS     = 4;
  localparam logic [11:0] IND_TMR_MAX   = 12'hfff;
  // Gate override states
  typedef enum logic [2:0] {
    MLFM_GATE_NORMAL = 3'b000,
    MLFM_GATE_OFF    = 3'b001,
    MLFM_GATE_RECIRC = 3'b010,
    MLFM_GATE_HIGH   = 3'b011,
    MLFM_GATE_LOW    = 3'b100
  } mlfm_gate_t;
  typedef enum logic [1:0] {
    MLFM_IDLE    = 2'b00,
    MLFM_LATCHED = 2'b01,
    MLFM_RETRY   = 2'b10,
    MLFM_REPORT  = 2'b11
  } mlfm_state_t;
  typedef enum logic [1:0] {
    MLFM_IND_IDLE = 2'b00,
    MLFM_IND_UP   = 2'b01,
    MLFM_IND_DOWN = 2'b10
  } mlfm_ind_t;
endpackage : mlfm_pkg

// [hdl/mlfm_top.sv]
// Lock-current, motor-lock and inductance-detect fault manager.
// Assumes digitised current, speed and zero-crossing inputs on clk_i.
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
module mlfm_top
  import mlfm_pkg::*;
#(
  parameter int unsigned CUR_W = 12,
  parameter int unsigned SPD_W = 16
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic              wb_we_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic [CUR_W-1:0]  current_sense_amp_i,
  input  wire logic [CUR_W-1:0]  lowside_current_i,
  input  wire logic [SPD_W-1:0]  speed_est_i,
  input  wire logic              zc_window_i,
  input  wire logic              zc_detect_i,
  input  wire logic              ind_pulse_start_i,
  input  wire logic              ind_pulse_end_i,
  output mlfm_pkg::mlfm_gate_t   gate_override_o,
  output logic                   fault_pin_n_o,
  output logic                   ind_retry_o
);
  import mlfm_pkg::*;

  // Wider fields would not fit their register slots
  if (CUR_W < 1 || CUR_W > 16 || SPD_W < 1 || SPD_W > 16) begin : g_bad_width
    $error("mlfm_top: widths must be 1 to 16");
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0] cfg;
  logic [31:0] thr;
  logic [31:0] tim;
  logic [8:0]  status;
  logic        clr_pulse;
  wire         wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Writes land on the edge where the master samples ack high
  wire         wb_wr   = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  wire  [31:0] wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                          {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire  [3:0]  lc_mode = cfg[CF_LC_MODE +: 4];
  wire  [3:0]  ml_mode = cfg[CF_ML_MODE +: 4];
  wire  [3:0]  miss_lim = cfg[CF_MISS_CNT +: 4];
  // Thresholds: lock current, absent current, overspeed
  wire  [CUR_W-1:0] lc_thr  = thr[CUR_W-1:0];
  wire  [CUR_W-1:0] ab_thr  = thr[16 +: CUR_W];
  logic [SPD_W-1:0] spd_thr;
  // Timing: deglitch counts and retry count, in clock cycles
  wire  [7:0]  lc_deg   = tim[7:0];
  wire  [7:0]  ab_deg   = tim[15:8];
  wire  [15:0] retry_cy = tim[31:16];
  wire  [31:0] rd_word  = (wb_adr_i == REG_CONFIG) ? cfg :
                          (wb_adr_i == REG_THRESH) ? thr :
                          (wb_adr_i == REG_TIMING) ? tim :
                          (wb_adr_i == REG_CONTROL) ? {{(32-SPD_W){1'b0}}, spd_thr} :
                          (wb_adr_i == REG_STATUS) ? {23'h000000, status} : 32'h0000_0000;

  // Wishbone slave: one wait state, ack for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      cfg      <= CONFIG_RST;
      thr      <= THRESH_RST;
      tim      <= TIMING_RST;
      spd_thr  <= '1;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= rd_word;
      if (wb_wr && wb_adr_i == REG_CONFIG) cfg <= (cfg & ~wmask) | (wb_dat_i & wmask);
      if (wb_wr && wb_adr_i == REG_THRESH) thr <= (thr & ~wmask) | (wb_dat_i & wmask);
      if (wb_wr && wb_adr_i == REG_TIMING) tim <= (tim & ~wmask) | (wb_dat_i & wmask);
      if (wb_wr && wb_adr_i == REG_CONTROL && wb_sel_i[1:0] == 2'b11) begin
        spd_thr <= wb_dat_i[SPD_W-1:0];
      end
    end
  end

  // clear-fault pulse on write of one to status bit 31
  assign clr_pulse = wb_wr & (wb_adr_i == REG_STATUS) & wb_sel_i[3] & wb_dat_i[31];

  //////////////////////////////////////////////////////////////////////////
  // Detectors
  logic [7:0] lc_cnt;
  logic [7:0] ab_cnt;
  logic [3:0] miss_cnt;
  logic       lc_hit;
  logic       ab_hit;
  logic       sync_hit;
  wire        lc_over  = current_sense_amp_i > lc_thr;
  wire        ab_under = lowside_current_i < ab_thr;
  wire        spd_hit  = cfg[CF_SPD_EN] & (speed_est_i > spd_thr);
  wire        miss_ev  = zc_window_i & ~zc_detect_i;

  // lock-current deglitch; absent deglitch; miss counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lc_cnt   <= 8'h00;
      ab_cnt   <= 8'h00;
      miss_cnt <= 4'h0;
      lc_hit   <= 1'b0;
      ab_hit   <= 1'b0;
      sync_hit <= 1'b0;
    end else begin
      lc_cnt   <= lc_over ? ((lc_cnt == 8'hff) ? lc_cnt : lc_cnt + 8'h01) : 8'h00;
      lc_hit   <= lc_over & (lc_cnt >= lc_deg);
      ab_cnt   <= ab_under ? ((ab_cnt == 8'hff) ? ab_cnt : ab_cnt + 8'h01) : 8'h00;
      ab_hit   <= cfg[CF_ABS_EN] & ab_under & (ab_cnt >= ab_deg);
      if (zc_detect_i) begin
        miss_cnt <= 4'h0;
      end else if (miss_ev && miss_cnt != 4'hf) begin
        miss_cnt <= miss_cnt + 4'h1;
      end
      sync_hit <= cfg[CF_SYNC_EN] & (miss_lim != 4'h0) & (miss_cnt >= miss_lim);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Action decode shared by both handlers
  function automatic mlfm_state_t mode_kind(input logic [3:0] m);
    // codes 1xx1 and undefined 1xxx act as disabled
    if (m[3:2] == 2'b00) mode_kind = MLFM_LATCHED;
    else if (m[3:2] == 2'b01) mode_kind = MLFM_RETRY;
    else if (m == 4'b1000) mode_kind = MLFM_REPORT;
    else mode_kind = MLFM_IDLE;
  endfunction

  function automatic mlfm_gate_t gate_sel(input logic [1:0] m);
    case (m)
      2'b00:   gate_sel = MLFM_GATE_OFF;
      2'b01:   gate_sel = MLFM_GATE_RECIRC;
      2'b10:   gate_sel = MLFM_GATE_HIGH;
      default: gate_sel = MLFM_GATE_LOW;
    endcase
  endfunction

  mlfm_state_t lc_st;
  mlfm_state_t ml_st;
  logic [15:0] lc_rt;
  logic [15:0] ml_rt;
  wire  mlk_ev   = spd_hit | sync_hit | ab_hit;
  wire  lc_kind_ok = (mode_kind(lc_mode) != MLFM_IDLE);
  wire  ml_kind_ok = (mode_kind(ml_mode) != MLFM_IDLE);
  // Clear is honoured only once the condition is gone
  wire  lc_clr   = clr_pulse & ~lc_hit;
  wire  ml_clr   = clr_pulse & ~mlk_ev;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lc_st <= MLFM_IDLE;
      lc_rt <= 16'h0000;
    end else begin
      case (lc_st)
        MLFM_IDLE: begin
          if (lc_hit && lc_kind_ok) begin
            lc_st <= mode_kind(lc_mode);
            lc_rt <= retry_cy;
          end
        end
        MLFM_RETRY: begin
          if (lc_rt == 16'h0000) lc_st <= MLFM_IDLE;
          else lc_rt <= lc_rt - 16'h0001;
        end
        MLFM_LATCHED, MLFM_REPORT: begin
          if (lc_clr) lc_st <= MLFM_IDLE;
        end
        default: lc_st <= MLFM_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ml_st <= MLFM_IDLE;
      ml_rt <= 16'h0000;
    end else begin
      case (ml_st)
        MLFM_IDLE: begin
          if (mlk_ev && ml_kind_ok) begin
            ml_st <= mode_kind(ml_mode);
            ml_rt <= retry_cy;
          end
        end
        MLFM_RETRY: begin
          if (ml_rt == 16'h0000) ml_st <= MLFM_IDLE;
          else ml_rt <= ml_rt - 16'h0001;
        end
        MLFM_LATCHED, MLFM_REPORT: begin
          if (ml_clr) ml_st <= MLFM_IDLE;
        end
        default: ml_st <= MLFM_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Inductance-detect timing
  mlfm_ind_t   ind_st;
  logic [11:0] ind_tmr;
  logic [9:0]  ind_pre;
  logic [1:0]  ind_step;
  logic        ind_up_f;
  logic        ind_dn_f;
  logic        ind_rate_f;
  logic [9:0]  pre_lim;
  wire  ind_on    = cfg[CF_STARTUP +: 2] == STARTUP_IND;
  wire  ind_thr_hit = current_sense_amp_i >= thr[16 +: CUR_W];
  wire  ind_zero  = current_sense_amp_i == '0;
  wire  tick      = ind_pre == pre_lim;
  wire  ovf       = tick & (ind_tmr == IND_TMR_MAX);
  wire  last_step = ind_step == 2'(IND_STEPS - 1);

  // Prescale per step: divide by 1, 10, 100, 1000
  always_comb begin
    case (ind_step)
      2'd0:    pre_lim = 10'd0;
      2'd1:    pre_lim = 10'd9;
      2'd2:    pre_lim = 10'd99;
      default: pre_lim = 10'd999;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ind_st     <= MLFM_IND_IDLE;
      ind_tmr    <= 12'h000;
      ind_pre    <= 10'd0;
      ind_step   <= 2'd0;
      ind_up_f   <= 1'b0;
      ind_dn_f   <= 1'b0;
      ind_rate_f <= 1'b0;
      ind_retry_o <= 1'b0;
    end else begin
      ind_retry_o <= 1'b0;
      ind_pre <= tick ? 10'd0 : ind_pre + 10'd1;
      if (tick) ind_tmr <= ind_tmr + 12'h001;
      // Set beats clear for each sticky flag
      if (clr_pulse) begin
        ind_up_f   <= 1'b0;
        ind_dn_f   <= 1'b0;
        ind_rate_f <= 1'b0;
      end
      if (ind_on && ind_pulse_start_i && ind_st == MLFM_IND_DOWN) ind_rate_f <= 1'b1;
      case (ind_st)
        MLFM_IND_IDLE: begin
          if (ind_on && ind_pulse_start_i) begin
            ind_st <= MLFM_IND_UP;
            ind_tmr <= 12'h000;
            ind_pre <= 10'd0;
            ind_step <= 2'd0;
          end
        end
        MLFM_IND_UP: begin
          if (ind_thr_hit || ind_pulse_end_i) begin
            ind_st <= MLFM_IND_DOWN;
            ind_tmr <= 12'h000;
            ind_pre <= 10'd0;
            ind_step <= 2'd0;
          end else if (ovf) begin
            ind_tmr <= 12'h000;
            ind_pre <= 10'd0;
            ind_retry_o <= ~last_step;
            ind_step <= ind_step + 2'd1;
            if (last_step) begin
              ind_up_f <= 1'b1;
              ind_st <= MLFM_IND_IDLE;
            end
          end
        end
        MLFM_IND_DOWN: begin
          if (ind_zero) begin
            ind_st <= MLFM_IND_IDLE;
          end else if (ovf) begin
            ind_tmr <= 12'h000;
            ind_pre <= 10'd0;
            ind_retry_o <= ~last_step;
            ind_step <= ind_step + 2'd1;
            if (last_step) begin
              ind_dn_f <= 1'b1;
              ind_st <= MLFM_IND_IDLE;
            end
          end
        end
        default: ind_st <= MLFM_IND_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status, detector bits captured while a motor lock is held
  logic [2:0] det_bits;
  wire  lc_act = lc_st != MLFM_IDLE;
  wire  ml_act = ml_st != MLFM_IDLE;
  wire  ml_entry = (ml_st == MLFM_IDLE) & mlk_ev & ml_kind_ok;

  // detector bits held with the motor-lock state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      det_bits <= 3'b000;
    end else if (ml_entry || ml_act) begin
      det_bits <= (ml_entry ? 3'b000 : det_bits) | {ab_hit, sync_hit, spd_hit};
    end else begin
      det_bits <= 3'b000;
    end
  end

  assign status = {ind_rate_f, ind_dn_f, ind_up_f,
                   det_bits[2] & ml_act, det_bits[1] & ml_act, det_bits[0] & ml_act,
                   ml_act, lc_act, lc_act | ml_act};

  // Gate and fault pin outputs; lock current outranks motor lock
  wire lc_drive = (lc_st == MLFM_LATCHED) | (lc_st == MLFM_RETRY);
  wire ml_drive = (ml_st == MLFM_LATCHED) | (ml_st == MLFM_RETRY);
  mlfm_gate_t next_gate;
  assign next_gate = lc_drive ? gate_sel(lc_mode[1:0]) :
                     ml_drive ? gate_sel(ml_mode[1:0]) : MLFM_GATE_NORMAL;

  // fault pin low only in protective states
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_override_o <= MLFM_GATE_NORMAL;
      fault_pin_n_o   <= 1'b1;
    end else begin
      gate_override_o <= next_gate;
      fault_pin_n_o   <= ~(lc_drive | ml_drive);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  // latched stays until clear
  a_lc_latch_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (lc_st == MLFM_LATCHED && !clr_pulse) |=> lc_st == MLFM_LATCHED)
    else $error("latched lock-current left without clear");
  a_pin_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    (lc_drive || ml_drive) |=> !fault_pin_n_o)
    else $error("fault pin not low during protection");
  a_report_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (lc_st == MLFM_REPORT && !ml_drive) |=> gate_override_o == MLFM_GATE_NORMAL)
    else $error("report mode overrode gates");
  a_lc_disabled: assert property (@(posedge clk_i) disable iff (rst_i)
    (lc_st == MLFM_IDLE && lc_mode[3] && lc_mode[0]) |=> lc_st == MLFM_IDLE)
    else $error("disabled lock-current mode acted");
  a_ml_disabled: assert property (@(posedge clk_i) disable iff (rst_i)
    (ml_st == MLFM_IDLE && ml_mode[3] && ml_mode[0]) |=> ml_st == MLFM_IDLE)
    else $error("disabled motor-lock mode acted");
  a_ml_retry_end: assert property (@(posedge clk_i) disable iff (rst_i)
    (ml_st == MLFM_RETRY && ml_rt == 16'h0000) |=> ml_st == MLFM_IDLE)
    else $error("motor-lock retry did not end");
  a_zc_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    zc_detect_i |=> miss_cnt == 4'h0)
    else $error("miss count not cleared on crossing");
  // overspeed raises motor lock in latched mode
  a_spd_lock: assert property (@(posedge clk_i) disable iff (rst_i)
    (spd_hit && ml_st == MLFM_IDLE && ml_mode[3:2] == 2'b00) |=> ml_st == MLFM_LATCHED)
    else $error("overspeed did not latch motor lock");
  a_rate_fault: assert property (@(posedge clk_i) disable iff (rst_i)
    (ind_on && ind_pulse_start_i && ind_st == MLFM_IND_DOWN) |=> ind_rate_f)
    else $error("pulse rate fault missed");

endmodule : mlfm_top

// [sim/mlfm_bridge_model.sv]
// Behavioural model of the external MOSFET half-bridges and the motor.
// Assumes gate commands from the fault manager on the same clock.
module mlfm_bridge_model
  import mlfm_pkg::*;
#(
  parameter int unsigned CUR_W = 12
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  mlfm_pkg::mlfm_gate_t  gate_i,
  input  wire logic [CUR_W-1:0] level_i,
  output logic      [CUR_W-1:0] csa_o,
  output logic      [CUR_W-1:0] lowside_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Any override takes supply off the shunt, so sensed current falls to zero;
  // the one-cycle lag stands in for the amplifier and converter delay
  always_ff @(posedge clk_i) begin
    if (rst_i || gate_i != MLFM_GATE_NORMAL) begin
      csa_o <= '0;
    end else begin
      csa_o <= level_i;
    end
  end

  // Low-side phase carries the same current in this simple motor
  assign lowside_o = csa_o;
endmodule // mlfm_bridge_model

// [sim/mlfm_top_tb.sv]
// Self-checking bench for the fault manager top level.
// Assumes the bridge model closes the current loop through the gates.
module mlfm_top_tb
  import mlfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat_w = 32'h0;
  logic [3:0]  sel = 4'h0;
  logic        we = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic [31:0] dat_r;
  logic        ack;
  logic [11:0] level = 12'h0;
  logic [11:0] current_sense_amp;
  logic [11:0] lows;
  logic [15:0] speed = 16'h0;
  logic        zc_win = 1'b0;
  logic        zc_det = 1'b0;
  logic        p_start = 1'b0;
  logic        p_end = 1'b0;
  mlfm_gate_t  gate;
  logic        fault_n;
  logic        retry;
  logic [31:0] q;
  int          errors = 0;
  int          comparisons = 0;
  int          n;

  mlfm_top u_mlfm_top (.clk_i(clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(dat_w),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .current_sense_amp_i(current_sense_amp), .lowside_current_i(lows),
    .speed_est_i(speed), .zc_window_i(zc_win), .zc_detect_i(zc_det),
    .ind_pulse_start_i(p_start), .ind_pulse_end_i(p_end), .gate_override_o(gate),
    .fault_pin_n_o(fault_n), .ind_retry_o(retry));

  mlfm_bridge_model u_mlfm_bridge_model (.clk_i(clk), .rst_i(rst), .gate_i(gate),
    .level_i(level), .csa_o(current_sense_amp), .lowside_o(lows));

  // 10 MHz clock
  initial begin
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Classic Wishbone cycle; ack is read as sampled at the edge
  task automatic bus(input logic [7:0] a, input logic w, input logic [3:0] s,
                     input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    adr <= a;
    we <= w;
    sel <= s;
    dat_w <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    @(posedge clk);
    while (ack !== 1'b1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    if (ack !== 1'b1) begin
      errors++;
      $display("Error bus_ack expected 1 seen %b", ack);
    end
    r = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    bus(a, 1'b1, s, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(a, 1'b0, 4'hf, 32'h0, r);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bounded wait for the fault pin level
  task automatic wait_pin(input logic v, input int lim);
    int k;
    k = 0;
    while (fault_n !== v && k < lim) begin
      @(posedge clk);
      k++;
    end
  endtask

  task automatic zc(input logic d);
    zc_win <= 1'b1;
    zc_det <= d;
    @(posedge clk);
    zc_win <= 1'b0;
    zc_det <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic ipulse(input logic e);
    p_start <= !e;
    p_end <= e;
    @(posedge clk);
    p_start <= 1'b0;
    p_end <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // One event in one mode code; ml selects motor lock over lock current
  task automatic run_mode(input logic ml, input logic [3:0] m);
    logic [31:0] r;
    logic [2:0]  g;
    logic [31:0] st;
    g = m[3] ? 3'd0 : 3'(m[1:0]) + 3'd1;
    st = (m <= 4'd8) ? (ml ? 32'h0000_000d : 32'h0000_0003) : 32'h0;
    wr(REG_CONFIG, ml ? {24'h000001, m, 4'h9} : {24'h000000, 4'h9, m}, 4'hf);
    if (ml) speed <= 16'd2000;
    else level <= 12'd200;
    @(posedge clk);
    wait_pin(1'b0, 40);
    repeat (2) @(posedge clk);
    chk("fault_pin", {31'h0, m[3]}, {31'h0, fault_n});
    chk("gate", {29'h0, g}, {29'h0, gate});
    rd(REG_STATUS, r);
    chk("status_set", st, r);
    speed <= 16'd0;
    level <= 12'd0;
    repeat (30) @(posedge clk);
    chk("pin_after", {31'h0, m[3:2] != 2'b00}, {31'h0, fault_n});
    // Auto-recovery must clear its own bits, so no clear command there
    if (m[3:2] != 2'b01) wr(REG_STATUS, 32'h8000_0000, 4'h8);
    rd(REG_STATUS, r);
    chk("status_end", 32'h0, r);
    chk("gate_end", 32'h0, {29'h0, gate});
  endtask

  task automatic give_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog sized well above the ~7k cycles the tests need
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    give_verdict();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset values and unmapped access
    rd(REG_CONFIG, q);
    chk("config_rst", CONFIG_RST, q);
    rd(REG_THRESH, q);
    chk("thresh_rst", THRESH_RST, q);
    rd(REG_TIMING, q);
    chk("timing_rst", TIMING_RST, q);
    rd(REG_STATUS, q);
    chk("status_rst", 32'h0, q);
    wr(8'h14, 32'h1234_5678, 4'hf);
    rd(8'h14, q);
    chk("unmapped", 32'h0, q);
    chk("pin_rst", 32'h1, {31'h0, fault_n});
    $display("test registers done");
    // Deglitch 4, absent deglitch 5, retry 8; thresholds 100, 50, speed 1000
    wr(REG_TIMING, 32'h0008_0504, 4'hf);
    wr(REG_THRESH, 32'h0032_0064, 4'hf);
    wr(REG_CONTROL, 32'h0000_03e8, 4'hf);
    // Over threshold for less than the deglitch time
    wr(REG_CONFIG, 32'h0000_0090, 4'hf);
    level <= 12'd200;
    repeat (3) @(posedge clk);
    level <= 12'd0;
    repeat (20) @(posedge clk);
    rd(REG_STATUS, q);
    chk("short_glitch", 32'h0, q);
    $display("test deglitch done");
    // Every mode code of both handlers
    for (int ml = 0; ml < 2; ml++) begin
      for (int m = 0; m < 16; m++) begin
        run_mode(1'(ml), 4'(m));
      end
    end
    $display("test modes done");
    // Misses interrupted by a crossing do not add up
    wr(REG_CONFIG, 32'h0000_3209, 4'hf);
    zc(1'b0);
    zc(1'b0);
    zc(1'b1);
    zc(1'b0);
    zc(1'b0);
    chk("sync_partial", 32'h1, {31'h0, fault_n});
    zc(1'b0);
    wait_pin(1'b0, 20);
    rd(REG_STATUS, q);
    chk("sync_status", 32'h15, q);
    zc(1'b1);
    wr(REG_STATUS, 32'h8000_0000, 4'h8);
    rd(REG_STATUS, q);
    chk("sync_clear", 32'h0, q);
    $display("test sync loss done");
    // Absent motor in report mode keeps the gates driving
    wr(REG_CONFIG, 32'h0000_0489, 4'hf);
    level <= 12'd200;
    repeat (10) @(posedge clk);
    level <= 12'd0;
    repeat (20) @(posedge clk);
    rd(REG_STATUS, q);
    chk("absent_status", 32'h25, q);
    level <= 12'd200;
    repeat (3) @(posedge clk);
    wr(REG_STATUS, 32'h8000_0000, 4'h8);
    rd(REG_STATUS, q);
    chk("absent_clear", 32'h0, q);
    $display("test absent done");
    // New pulse before the previous one decayed
    wr(REG_CONFIG, 32'h0002_0099, 4'hf);
    ipulse(1'b0);
    ipulse(1'b1);
    ipulse(1'b0);
    rd(REG_STATUS, q);
    chk("rate_fault", 32'h100, q & 32'h1c0);
    level <= 12'd0;
    repeat (5) @(posedge clk);
    wr(REG_STATUS, 32'h8000_0000, 4'h8);
    // Ramp that never reaches threshold overflows the first timer rate
    ipulse(1'b0);
    n = 4;
    while (retry !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chk("retry_gap", 32'h1, {31'h0, n >= 4090 && n <= 4110});
    level <= 12'd200;
    repeat (5) @(posedge clk);
    level <= 12'd0;
    ipulse(1'b1);
    repeat (20) @(posedge clk);
    rd(REG_STATUS, q);
    chk("ramp_faults", 32'h0, q & 32'h1c0);
    $display("test inductance done");
    give_verdict();
  end
endmodule // mlfm_top_tb
